// ### design/lsou_pkg.sv
// Shared constants and types for the limit and string operations unit.
// Assumes a 16-bit word machine with 15-bit word addresses and byte pointers
// whose low bit selects the byte (0 = bits 15:8, 1 = bits 7:0).
package lsou_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] REG_AC0    = 4'h0;
  localparam logic [3:0] REG_AC1    = 4'h1;
  localparam logic [3:0] REG_AC2    = 4'h2;
  localparam logic [3:0] REG_AC3    = 4'h3;
  localparam logic [3:0] REG_PC     = 4'h4;
  localparam logic [3:0] REG_CTRL   = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;

  // Control word fields (write only)
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_ACS_LSB   = 3;
  localparam int CTRL_ACD_LSB   = 5;

  // Status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;

  localparam logic [15:0] AC_RESET   = 16'h0000;
  localparam logic [14:0] PC_RESET   = 15'h0000;
  localparam logic [7:0]  SPACE_BYTE = 8'h20;
  localparam logic [15:0] CODE_LOWER = 16'hffff;
  localparam logic [15:0] CODE_EQUAL = 16'h0000;
  localparam logic [15:0] CODE_HIGHER = 16'h0001;

  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    LSOU_OP_LIMIT  = 2'h0,
    LSOU_OP_CMP    = 2'h1,
    LSOU_OP_MOVE   = 2'h2,
    LSOU_OP_BAD    = 2'h3
  } lsou_op_e;

  typedef enum logic [3:0] {
    S_IDLE, S_CLM_LO, S_CLM_HI, S_CLM_DEC,
    S_CMP_CHK, S_CMP_RD1, S_CMP_RD2, S_CMP_EVAL,
    S_CMT_IND, S_CMT_SRC, S_CMT_TAB, S_CMT_DRAIN
  } lsou_state_e;

  // One byte store toward memory
  typedef struct packed {
    logic [14:0] addr;
    logic        low_byte;
    logic [7:0]  data;
  } lsou_wr_s;

  localparam int WR_WIDTH = $bits(lsou_wr_s);

endpackage

// ### design/lsou_unit.sv
// Limit compare with skip, byte string compare and delimited byte move,
// plus the byte store FIFO that sits between the move engine and memory.
// Assumes a memory read port answering with a one-cycle ack on clk_sys,
// and a memory write port that may hold off stores with wr_ready.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lsou_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign out_valid = (wr_ptr != rd_ptr);
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_data  = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (in_valid && in_ready)
    begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// Contract
// - Skip next word when low limit <= signed source value <= high limit.
// - Different accumulators: low limit at destination bits 14:0, high next.
// - Same accumulator: limits follow instruction; third word is the next word.
// - Compare unsigned byte pairs; smaller byte at first mismatch is lower.
// - Accumulator zero/one hold signed lengths of strings two/one.
// - Accumulators two/three point into strings two/one from their start end.
// - Compare never writes memory; overlap does not alter the result.
// - Compare leaves remaining count and pointers at mismatch or past end.
// - Compare code: -1 string one lower, 0 equal, +1 higher.
// - Both lengths zero gives 0; shorter string padded with spaces.
// - Source byte indexes delimiter bit table; set bit stops without copy.
// - Table address from accumulator zero, indirection resolved first.
// - Source length sign sets one common direction for both strings.
// - Equal destination and source pointers: scan only, store nothing.
// - Move leaves table address, unmoved count and advanced pointers.
// - Zero move length: nothing fetched or stored, a no-operation.
// - A skip advances exactly one sequential 16-bit word.
module lsou_unit (
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  input  wire logic [3:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [15:0]     reg_rdata,
  output logic                 mem_rd_req,
  output logic      [14:0]     mem_rd_addr,
  input  wire logic            mem_rd_ack,
  input  wire logic [15:0]     mem_rd_data,
  output logic                 mem_wr_valid,
  input  wire logic            mem_wr_ready,
  output lsou_pkg::lsou_wr_s   mem_wr,
  output logic                 busy
);
  import lsou_pkg::*;

  lsou_state_e state;
  lsou_op_e    op;
  logic [15:0] ac [4];
  logic [14:0] pc;
  logic [1:0]  acs;
  logic [1:0]  acd;
  logic [14:0] lim_addr;
  logic [15:0] lim_lo;
  logic [15:0] lim_hi;
  logic        skip;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  src_byte;
  logic        start;
  lsou_op_e    cmd_op;
  logic [7:0]  rd_byte;
  logic        delim;
  logic        in_range;
  logic        push;
  logic        push_ready;
  lsou_wr_s    push_data;
  logic        fifo_busy;

  function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic desc);
    step_ptr = desc ? p - 16'h0001 : p + 16'h0001;
  endfunction

  function automatic logic [15:0] step_cnt(input logic [15:0] c);
    step_cnt = c[15] ? c + 16'h0001 : c - 16'h0001;
  endfunction

  assign busy     = (state != S_IDLE);
  assign cmd_op   = lsou_op_e'(reg_wdata[CTRL_OP_LSB +: 2]);
  assign start    = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_START_BIT]
                    && !busy && (cmd_op != LSOU_OP_BAD);
  // Byte 0 of a word is its high half; string two is read only in S_CMP_RD2
  assign rd_byte  = ((state == S_CMP_RD2) ? ac[2][0] : ac[3][0]) ? mem_rd_data[7:0]
                    : mem_rd_data[15:8];
  assign delim    = mem_rd_data[4'hf - src_byte[3:0]];
  assign in_range = ($signed(ac[acs]) >= $signed(lim_lo))
                    && ($signed(ac[acs]) <= $signed(lim_hi));

  // Read requests; table reads wait for FIFO room so a copied byte is never dropped
  always_comb
  begin
    mem_rd_req  = 1'b0;
    mem_rd_addr = lim_addr;
    unique case (state)
      S_CLM_LO:  mem_rd_req = 1'b1;
      S_CLM_HI:
      begin
        mem_rd_req  = 1'b1;
        mem_rd_addr = lim_addr + 15'h0001;
      end
      S_CMP_RD1, S_CMT_SRC:
      begin
        mem_rd_req  = 1'b1;
        mem_rd_addr = ac[3][15:1];
      end
      S_CMP_RD2:
      begin
        mem_rd_req  = 1'b1;
        mem_rd_addr = ac[2][15:1];
      end
      S_CMT_IND:
      begin
        mem_rd_req  = ac[0][15];
        mem_rd_addr = ac[0][14:0];
      end
      S_CMT_TAB:
      begin
        mem_rd_req  = push_ready;
        mem_rd_addr = ac[0][14:0] + {11'h000, src_byte[7:4]};
      end
      S_IDLE, S_CLM_DEC, S_CMP_CHK, S_CMP_EVAL, S_CMT_DRAIN: mem_rd_req = 1'b0;
    endcase
  end

  assign push = (state == S_CMT_TAB) && mem_rd_ack && !delim && (ac[2] != ac[3]);
  assign push_data = '{addr: ac[2][15:1], low_byte: ac[2][0], data: src_byte};

  // Sequencer and accumulators
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state    <= S_IDLE;
      op       <= LSOU_OP_LIMIT;
      ac       <= '{default: AC_RESET};
      pc       <= PC_RESET;
      acs      <= 2'h0;
      acd      <= 2'h0;
      lim_addr <= 15'h0000;
      lim_lo   <= 16'h0000;
      lim_hi   <= 16'h0000;
      skip     <= 1'b0;
      b1       <= 8'h00;
      b2       <= 8'h00;
      src_byte <= 8'h00;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (reg_wr && !busy && reg_addr <= REG_AC3)
          begin
            ac[reg_addr[1:0]] <= reg_wdata;
          end
          if (reg_wr && !busy && reg_addr == REG_PC)
          begin
            pc <= reg_wdata[14:0];
          end
          if (start)
          begin
            op  <= cmd_op;
            acs <= reg_wdata[CTRL_ACS_LSB +: 2];
            acd <= reg_wdata[CTRL_ACD_LSB +: 2];
            unique case (cmd_op)
              LSOU_OP_LIMIT:
              begin
                skip  <= 1'b0;
                state <= S_CLM_LO;
                if (reg_wdata[CTRL_ACS_LSB +: 2] == reg_wdata[CTRL_ACD_LSB +: 2])
                begin
                  lim_addr <= pc + 15'h0001;
                end
                else
                begin
                  lim_addr <= ac[reg_wdata[CTRL_ACD_LSB +: 2]][14:0];
                end
              end
              LSOU_OP_CMP:  state <= S_CMP_CHK;
              LSOU_OP_MOVE: state <= (ac[1] == 16'h0000) ? S_IDLE : S_CMT_IND;
              LSOU_OP_BAD:  state <= S_IDLE;
            endcase
          end
        end
        S_CLM_LO:
        begin
          if (mem_rd_ack)
          begin
            lim_lo <= mem_rd_data;
            state  <= S_CLM_HI;
          end
        end
        S_CLM_HI:
        begin
          if (mem_rd_ack)
          begin
            lim_hi <= mem_rd_data;
            state  <= S_CLM_DEC;
          end
        end
        S_CLM_DEC:
        begin
          // Limit words in line count as part of the instruction
          skip  <= in_range;
          pc    <= pc + ((acs == acd) ? 15'h0003 : 15'h0001)
                   + (in_range ? 15'h0001 : 15'h0000);
          state <= S_IDLE;
        end
        S_CMP_CHK:
        begin
          if (ac[0] == 16'h0000 && ac[1] == 16'h0000)
          begin
            ac[1] <= CODE_EQUAL;
            state <= S_IDLE;
          end
          else if (ac[1] != 16'h0000)
          begin
            state <= S_CMP_RD1;
          end
          else
          begin
            b1    <= SPACE_BYTE;
            state <= S_CMP_RD2;
          end
        end
        S_CMP_RD1:
        begin
          if (mem_rd_ack)
          begin
            b1 <= rd_byte;
            if (ac[0] != 16'h0000)
            begin
              state <= S_CMP_RD2;
            end
            else
            begin
              b2    <= SPACE_BYTE;
              state <= S_CMP_EVAL;
            end
          end
        end
        S_CMP_RD2:
        begin
          if (mem_rd_ack)
          begin
            b2    <= rd_byte;
            state <= S_CMP_EVAL;
          end
        end
        S_CMP_EVAL:
        begin
          // Pointers stay on the failing bytes
          if (b1 != b2)
          begin
            ac[1] <= (b1 < b2) ? CODE_LOWER : CODE_HIGHER;
            state <= S_IDLE;
          end
          else
          begin
            if (ac[1] != 16'h0000)
            begin
              ac[3] <= step_ptr(ac[3], ac[1][15]);
              ac[1] <= step_cnt(ac[1]);
            end
            if (ac[0] != 16'h0000)
            begin
              ac[2] <= step_ptr(ac[2], ac[0][15]);
              ac[0] <= step_cnt(ac[0]);
            end
            state <= S_CMP_CHK;
          end
        end
        S_CMT_IND:
        begin
          if (!ac[0][15])
          begin
            state <= S_CMT_SRC;
          end
          else if (mem_rd_ack)
          begin
            ac[0] <= mem_rd_data;
          end
        end
        S_CMT_SRC:
        begin
          if (mem_rd_ack)
          begin
            src_byte <= rd_byte;
            state    <= S_CMT_TAB;
          end
        end
        S_CMT_TAB:
        begin
          if (mem_rd_ack)
          begin
            if (delim)
            begin
              state <= S_CMT_DRAIN;
            end
            else
            begin
              ac[2] <= step_ptr(ac[2], ac[1][15]);
              ac[3] <= step_ptr(ac[3], ac[1][15]);
              ac[1] <= step_cnt(ac[1]);
              state <= (step_cnt(ac[1]) == 16'h0000) ? S_CMT_DRAIN : S_CMT_SRC;
            end
          end
        end
        S_CMT_DRAIN:
        begin
          // Done only once every store has left the FIFO
          if (!fifo_busy)
          begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      if (reg_addr <= REG_AC3)
      begin
        reg_rdata <= ac[reg_addr[1:0]];
      end
      else if (reg_addr == REG_PC)
      begin
        reg_rdata <= {1'b0, pc};
      end
      else if (reg_addr == REG_STATUS)
      begin
        reg_rdata <= 16'h0000 | (16'(busy) << STAT_BUSY_BIT) | (16'(skip) << STAT_SKIP_BIT);
      end
      else
      begin
        reg_rdata <= 16'h0000;
      end
    end
    else
    begin
      reg_rdata <= 16'h0000;
    end
  end

  lsou_fifo #(
    .WIDTH (WR_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_store_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (fifo_busy),
    .out_ready (mem_wr_ready),
    .out_data  (mem_wr)
  );

  assign mem_wr_valid = fifo_busy;

  chk_clm_diff_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == S_CLM_LO && acs != acd) |-> mem_rd_addr == ac[acd][14:0])
    else $error("limit address not from destination accumulator");
  chk_clm_same_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (start && cmd_op == LSOU_OP_LIMIT
     && reg_wdata[CTRL_ACS_LSB +: 2] == reg_wdata[CTRL_ACD_LSB +: 2])
    |=> mem_rd_addr == $past(pc) + 15'h0001 ##1 (state == S_CLM_LO || state == S_CLM_HI))
    else $error("in-line limit address wrong");
  chk_clm_skip_pc: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == S_CLM_DEC && acs != acd) |=> pc == $past(pc) + (skip ? 15'h0002 : 15'h0001))
    else $error("skip did not advance exactly one word");
  chk_cmp_no_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op == LSOU_OP_CMP && busy) |-> !push && !mem_wr_valid)
    else $error("string compare stored a byte");
  chk_cmp_zero_len: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == S_CMP_CHK && ac[0] == 16'h0000 && ac[1] == 16'h0000)
    |=> state == S_IDLE && ac[1] == CODE_EQUAL)
    else $error("empty compare not equal");
  chk_cmp_lower: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == S_CMP_EVAL && b1 < b2) |=> ac[1] == CODE_LOWER && state == S_IDLE)
    else $error("lower string code wrong");
  chk_cmt_zero_nop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (start && cmd_op == LSOU_OP_MOVE && ac[1] == 16'h0000) |=> state == S_IDLE [*2])
    else $error("zero length move did work");
  chk_cmt_delim_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == S_CMT_TAB && mem_rd_ack && delim) |-> !push ##1 state == S_CMT_DRAIN)
    else $error("delimiter byte copied");
  chk_cmt_same_ptr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op == LSOU_OP_MOVE && busy && ac[2] == ac[3]) |-> !push && !mem_wr_valid)
    else $error("store with equal pointers");
  chk_cmt_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == S_CMT_TAB && mem_rd_ack && !delim)
    |=> ac[3] == step_ptr($past(ac[3]), $past(ac[1][15])))
    else $error("source pointer step wrong");

  cov_clm_skip: cover property (@(posedge clk_sys) disable iff (!rst_b)
    state == S_CLM_DEC && in_range);
  cov_cmp_higher: cover property (@(posedge clk_sys) disable iff (!rst_b)
    state == S_CMP_EVAL && b1 > b2);
  cov_cmt_delim: cover property (@(posedge clk_sys) disable iff (!rst_b)
    state == S_CMT_TAB && mem_rd_ack && delim);
  cov_fifo_full: cover property (@(posedge clk_sys) disable iff (!rst_b)
    state == S_CMT_TAB && !push_ready);
endmodule

`default_nettype wire

// ### testbench/lsou_mem_model.sv
// Word memory model on the far side of the unit's read port and byte store port.
// Assumes the unit holds a read request until ack and stores bytes from its FIFO.
`timescale 1ns/1ps
`default_nettype none
module lsou_mem_model (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               slow,
  input  wire logic               stall,
  input  wire logic               mem_rd_req,
  input  wire logic [14:0]        mem_rd_addr,
  output logic                    mem_rd_ack,
  output logic      [15:0]        mem_rd_data,
  input  wire logic               mem_wr_valid,
  output logic                    mem_wr_ready,
  input  wire lsou_pkg::lsou_wr_s mem_wr,
  output logic      [15:0]        rd_count,
  output logic      [15:0]        wr_count
);
  import lsou_pkg::*;
  logic [15:0] mem [0:32767];
  logic [1:0]  wait_cnt;
  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 16'h0000;
  end
  assign mem_wr_ready = ~stall;
  // Outside an ack the data bus flips every cycle, so a late sample never matches
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      mem_rd_ack <= 1'b0;
      mem_rd_data <= 16'h5a5a;
      wait_cnt <= 2'h0;
      rd_count <= 16'h0000;
      wr_count <= 16'h0000;
    end
    else
    begin
      mem_rd_ack <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
      if (mem_rd_req && !mem_rd_ack)
      begin
        wait_cnt <= wait_cnt + 2'h1;
        if (!slow || wait_cnt == 2'h3)
        begin
          mem_rd_ack <= 1'b1;
          mem_rd_data <= mem[mem_rd_addr];
          rd_count <= rd_count + 16'h0001;
          wait_cnt <= 2'h0;
        end
      end
      if (mem_wr_valid && mem_wr_ready)
      begin
        if (mem_wr.low_byte)
          mem[mem_wr.addr][7:0] <= mem_wr.data;
        else
          mem[mem_wr.addr][15:8] <= mem_wr.data;
        wr_count <= wr_count + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the limit and string operations unit.
// Assumes the memory model sits on the unit's read and store ports.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lsou_pkg::*;
  logic        clk_sys, rst_b, reg_wr, reg_rd, slow, stall;
  logic        mem_rd_req, mem_rd_ack, mem_wr_valid, mem_wr_ready, busy;
  logic [3:0]  reg_addr;
  logic [14:0] mem_rd_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_rd_data, rd_count, wr_count, tmp;
  logic [15:0] ac [4];
  lsou_wr_s    mem_wr;
  int          err_total, n_compared;

  lsou_unit lsou_unit_i (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr(mem_wr), .busy(busy));
  lsou_mem_model lsou_mem_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
    .stall(stall), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr), .rd_count(rd_count),
    .wr_count(wr_count));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task conclude;
    $display("mismatches %0d comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task exec(input logic [1:0] op, input logic [1:0] acs, input logic [1:0] acd,
            input logic [15:0] a0, input logic [15:0] a1, input logic [15:0] a2,
            input logic [15:0] a3);
    int n;
    wr(REG_AC0, a0);
    wr(REG_AC1, a1);
    wr(REG_AC2, a2);
    wr(REG_AC3, a3);
    wr(REG_CTRL, {9'h000, acd, acs, op, 1'b1});
    #1;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check({15'h0000, n < 4000}, 16'h0001);
    for (int i = 0; i < 4; i++)
      rd(i[3:0], ac[i]);
  endtask

  task expect4(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2,
               input logic [15:0] e3);
    check(ac[0], e0);
    check(ac[1], e1);
    check(ac[2], e2);
    check(ac[3], e3);
  endtask

  task t_regs;
    for (int i = 0; i < 8; i++)
    begin
      rd(i[3:0], tmp);
      check(tmp, 16'h0000);
    end
    rd(4'hf, tmp);
    check(tmp, 16'h0000);
    wr(REG_CTRL, 16'h0007);
    #1;
    check({15'h0000, busy}, 16'h0000);
  endtask

  task t_limit;
    logic [15:0] v [4];
    v = '{16'hfff0, 16'h0010, 16'h0011, 16'hffef};
    lsou_mem_model_i.mem[15'h0400] = 16'hfff0;
    lsou_mem_model_i.mem[15'h0401] = 16'h0010;
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_PC, 16'h0050);
      exec(LSOU_OP_LIMIT, 2'h1, 2'h0, 16'h8400, v[i], 16'h0000, 16'h0000);
      rd(REG_STATUS, tmp);
      check({15'h0000, tmp[STAT_SKIP_BIT]}, {15'h0000, i < 2});
      rd(REG_PC, tmp);
      check(tmp, (i < 2) ? 16'h0052 : 16'h0051);
    end
    slow <= 1'b1;
    lsou_mem_model_i.mem[15'h0061] = 16'h0005;
    lsou_mem_model_i.mem[15'h0062] = 16'h0007;
    for (int j = 0; j < 2; j++)
    begin
      wr(REG_PC, 16'h0060);
      exec(LSOU_OP_LIMIT, 2'h2, 2'h2, 16'h0000, 16'h0000, (j == 0) ? 16'h0006 : 16'h0008,
           16'h0000);
      rd(REG_STATUS, tmp);
      check({15'h0000, tmp[STAT_SKIP_BIT]}, {15'h0000, j == 0});
      rd(REG_PC, tmp);
      check(tmp, (j == 0) ? 16'h0064 : 16'h0063);
    end
    slow <= 1'b0;
  endtask

  task t_compare;
    logic [15:0] w0;
    lsou_mem_model_i.mem[15'h0100] = 16'h4142;
    lsou_mem_model_i.mem[15'h0101] = 16'h4300;
    lsou_mem_model_i.mem[15'h0110] = 16'h4142;
    lsou_mem_model_i.mem[15'h0111] = 16'h4400;
    lsou_mem_model_i.mem[15'h0118] = 16'h4142;
    lsou_mem_model_i.mem[15'h0119] = 16'h2000;
    lsou_mem_model_i.mem[15'h0120] = 16'h3350;
    lsou_mem_model_i.mem[15'h0130] = 16'h3340;
    w0 = wr_count;
    exec(LSOU_OP_CMP, 2'h0, 2'h0, 16'h0003, 16'h0003, 16'h0220, 16'h0200);
    expect4(16'h0001, 16'hffff, 16'h0222, 16'h0202);
    exec(LSOU_OP_CMP, 2'h0, 2'h0, 16'h0003, 16'h0002, 16'h0230, 16'h0200);
    expect4(16'h0000, 16'h0000, 16'h0233, 16'h0202);
    exec(LSOU_OP_CMP, 2'h0, 2'h0, 16'hfffe, 16'hfffe, 16'h0261, 16'h0241);
    expect4(16'hfffe, 16'h0001, 16'h0261, 16'h0241);
    exec(LSOU_OP_CMP, 2'h0, 2'h0, 16'h0000, 16'h0000, 16'h0220, 16'h0200);
    expect4(16'h0000, 16'h0000, 16'h0220, 16'h0200);
    check(wr_count, w0);
  endtask

  task t_move;
    logic [15:0] w0;
    logic [15:0] r0;
    lsou_mem_model_i.mem[15'h0302] = 16'h0002;
    lsou_mem_model_i.mem[15'h0200] = 16'h4142;
    lsou_mem_model_i.mem[15'h0201] = 16'h2e43;
    w0 = wr_count;
    exec(LSOU_OP_MOVE, 2'h0, 2'h0, 16'h0300, 16'h0004, 16'h0500, 16'h0400);
    expect4(16'h0300, 16'h0002, 16'h0502, 16'h0402);
    check(lsou_mem_model_i.mem[15'h0280], 16'h4142);
    check(lsou_mem_model_i.mem[15'h0281], 16'h0000);
    check(wr_count, w0 + 16'h0002);
    exec(LSOU_OP_MOVE, 2'h0, 2'h0, 16'h0300, 16'h0004, 16'h0400, 16'h0400);
    expect4(16'h0300, 16'h0002, 16'h0402, 16'h0402);
    check(wr_count, w0 + 16'h0002);
    r0 = rd_count;
    exec(LSOU_OP_MOVE, 2'h0, 2'h0, 16'h0300, 16'h0000, 16'h0500, 16'h0400);
    expect4(16'h0300, 16'h0000, 16'h0500, 16'h0400);
    check(rd_count, r0);
    check(wr_count, w0 + 16'h0002);
  endtask

  // Descending move of 20 bytes through an indirect table pointer while stores stall,
  // so the store FIFO fills to its depth before memory accepts anything
  task t_move_long;
    logic [15:0] w0;
    for (int i = 0; i < 10; i++)
      lsou_mem_model_i.mem[15'h0220 + i] = 16'(16'h0101 * (i + 1));
    lsou_mem_model_i.mem[15'h03f0] = 16'h0310;
    w0 = wr_count;
    stall <= 1'b1;
    fork
      exec(LSOU_OP_MOVE, 2'h0, 2'h0, 16'h83f0, 16'hffec, 16'h0553, 16'h0453);
      begin
        repeat (150) @(posedge clk_sys);
        #1;
        check(wr_count, w0);
        check({15'h0000, busy}, 16'h0001);
        wr(REG_AC0, 16'h1234);
        stall <= 1'b0;
      end
    join
    expect4(16'h0310, 16'h0000, 16'h053f, 16'h043f);
    for (int i = 0; i < 10; i++)
      check(lsou_mem_model_i.mem[15'h02a0 + i], 16'(16'h0101 * (i + 1)));
  endtask

  initial
  begin
    #400us;
    err_total++;
    conclude;
  end

  initial
  begin
    err_total = 0;
    n_compared = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    slow = 1'b0;
    stall = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs;
    t_limit;
    t_compare;
    t_move;
    t_move_long;
    conclude;
  end
endmodule
`default_nettype wire
